// *** cam_pkg.sv ***
// constants, operation codes and carriers for the multiply, compare and bit unit
package cam_pkg;

    localparam int          CAM_W       = 8;
    localparam int          CAM_IW      = 3;
    localparam int          CAM_PW      = 2 * CAM_W;
    localparam logic [7:0]  CAM_A_RST   = 8'h00;
    localparam logic [7:0]  CAM_D_RST   = 8'h00;
    localparam logic        CAM_C_RST   = 1'b0;
    localparam logic        CAM_V_RST   = 1'b0;
    localparam logic        CAM_Z_RST   = 1'b0;
    localparam int          CAM_RSP_LAT = 1;
    localparam int          CAM_SF_C    = 7;
    localparam int          CAM_SF_V    = 6;
    localparam int          CAM_SF_Z    = 5;
    localparam int          CAM_SIGN    = 7;

    typedef enum logic [4:0] {
        CAM_OP_NOP      = 5'h00,
        CAM_OP_MUL_RR   = 5'h01,
        CAM_OP_MUL_RRR  = 5'h02,
        CAM_OP_MUL_MEM  = 5'h03,
        CAM_OP_MUL_IMM  = 5'h04,
        CAM_OP_MSHL     = 5'h05,
        CAM_OP_MSHR     = 5'h06,
        CAM_OP_MSHRA    = 5'h07,
        CAM_OP_CMP_IMM  = 5'h08,
        CAM_OP_CMP_RR   = 5'h09,
        CAM_OP_CMP_MEM  = 5'h0A,
        CAM_OP_TSTB     = 5'h0B,
        CAM_OP_SETB     = 5'h0C,
        CAM_OP_CLRB     = 5'h0D,
        CAM_OP_INVB     = 5'h0E,
        CAM_OP_SFLAG    = 5'h0F,
        CAM_OP_RFLAG_R  = 5'h10,
        CAM_OP_RFLAG_M  = 5'h11
    } cam_op_t;

    typedef enum logic [1:0] {
        CAM_MS_MUL  = 2'b00,
        CAM_MS_SHL  = 2'b01,
        CAM_MS_SHR  = 2'b10,
        CAM_MS_SHRA = 2'b11
    } cam_ms_t;

    typedef struct packed {
        cam_op_t     op;
        logic [7:0]  reg1;
        logic [7:0]  reg2;
        logic [7:0]  reg3;
        logic [7:0]  data_memory;
        logic [7:0]  imm;
        logic [2:0]  idx;
    } cam_req_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  a;
        logic [7:0]  dest;
        logic        dest_we;
        logic        c;
        logic        v;
        logic        z;
    } cam_state_t;

endpackage

// *** cam_mulsh.sv ***
// combinational multiplier and multiply-based shifter
`timescale 1ns/10ps
module cam_mulsh
    import cam_pkg::*;
#(
    parameter int W  = CAM_W,
    parameter int IW = CAM_IW
) (
    input  wire logic [W-1:0]   x,
    input  wire logic [W-1:0]   y,
    input  wire cam_ms_t        mode,
    input  wire logic [IW-1:0]  sh,
    output logic [2*W-1:0]      p
);

    // shift amounts must cover exactly one operand width
    generate
        if (W != (1 << IW)) begin : g_bad_width
            $error("cam_mulsh: W must equal 2**IW");
        end
    endgenerate

    logic [2*W-1:0] xw;
    logic [2*W-1:0] yw;
    logic [2*W-1:0] xhi;

    always_comb begin
        xw  = {{W{1'b0}}, x};
        yw  = {{W{1'b0}}, y};
        xhi = {x, {W{1'b0}}};
        case (mode)
            CAM_MS_MUL:  p = xw * yw;
            CAM_MS_SHL:  p = xw << sh;
            // shifted-out bits land at the top of the low byte
            CAM_MS_SHR:  p = xhi >> sh;
            CAM_MS_SHRA: p = $unsigned($signed(xhi) >>> sh);
            default:     p = '0;
        endcase
    end

endmodule

// *** cam_alu.sv ***
// multiply, shift, compare, bit and flag save/restore unit of the cpu datapath
`timescale 1ns/10ps
module cam_alu
    import cam_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rstn,
    input  wire logic      req_valid,
    input  wire cam_req_t  req,
    output logic           rsp_valid,
    output logic [7:0]     a_q,
    output logic [7:0]     dest_q,
    output logic           dest_we,
    output logic           c_q,
    output logic           v_q,
    output logic           z_q
);

    localparam cam_state_t CAM_ST_RST = '{
        valid:   1'b0,
        a:       CAM_A_RST,
        dest:    CAM_D_RST,
        dest_we: 1'b0,
        c:       CAM_C_RST,
        v:       CAM_V_RST,
        z:       CAM_Z_RST
    };

    cam_state_t     st_q;
    cam_state_t     st_d;

    logic [7:0]     ms_x;
    logic [7:0]     ms_y;
    cam_ms_t        ms_mode;
    logic [15:0]    ms_p;
    logic [7:0]     cmp_x;
    logic [8:0]     cmp_diff;
    logic [7:0]     bit_mask;
    logic [7:0]     rf_src;

    // operand steering for the shared multiplier
    always_comb begin
        ms_x    = req.reg1;
        ms_y    = req.reg2;
        ms_mode = CAM_MS_MUL;
        case (req.op)
            CAM_OP_MUL_RR: begin
                ms_x = req.reg2;
                ms_y = req.reg1;
            end
            CAM_OP_MUL_RRR: begin
                ms_x = req.reg2;
                ms_y = req.reg3;
            end
            CAM_OP_MUL_MEM: begin
                ms_x = req.data_memory;
                ms_y = req.reg1;
            end
            CAM_OP_MUL_IMM: begin
                ms_x = req.imm;
                ms_y = req.reg1;
            end
            CAM_OP_MSHL: begin
                ms_mode = CAM_MS_SHL;
            end
            CAM_OP_MSHR: begin
                ms_mode = CAM_MS_SHR;
            end
            CAM_OP_MSHRA: begin
                ms_mode = CAM_MS_SHRA;
            end
            default: begin
                ms_mode = CAM_MS_MUL;
            end
        endcase
    end

    cam_mulsh #(
        .W  (CAM_W),
        .IW (CAM_IW)
    ) u_mulsh (
        .x    (ms_x),
        .y    (ms_y),
        .mode (ms_mode),
        .sh   (req.idx),
        .p    (ms_p)
    );

    // minuend for compare (reg2 in the register form); subtrahend is always reg1
    always_comb begin
        case (req.op)
            CAM_OP_CMP_IMM: cmp_x = req.imm;
            CAM_OP_CMP_MEM: cmp_x = req.data_memory;
            default:        cmp_x = req.reg2;
        endcase
        cmp_diff = {1'b0, cmp_x} - {1'b0, req.reg1};
        bit_mask = 8'h01 << req.idx;
        rf_src   = (req.op == CAM_OP_RFLAG_M) ? req.data_memory : req.reg1;
    end

    always_comb begin
        st_d         = st_q;
        st_d.valid   = 1'b0;
        st_d.dest_we = 1'b0;
        if (req_valid) begin
            st_d.valid = 1'b1;
            case (req.op)
                // flags deliberately held: undefined after products
                CAM_OP_MUL_RR, CAM_OP_MUL_RRR, CAM_OP_MUL_MEM, CAM_OP_MUL_IMM,
                CAM_OP_MSHL, CAM_OP_MSHR, CAM_OP_MSHRA: begin
                    st_d.a       = ms_p[7:0];
                    st_d.dest    = ms_p[15:8];
                    st_d.dest_we = 1'b1;
                end
                CAM_OP_CMP_IMM, CAM_OP_CMP_RR, CAM_OP_CMP_MEM: begin
                    st_d.a = cmp_diff[7:0];
                    st_d.c = ~cmp_diff[8];
                    st_d.z = (cmp_diff[7:0] == 8'h00);
                    st_d.v = ~cmp_diff[8] & (cmp_diff[7:0] != 8'h00);
                end
                CAM_OP_TSTB: begin
                    st_d.a = req.reg1 & bit_mask;
                    st_d.z = ((req.reg1 & bit_mask) == 8'h00);
                end
                CAM_OP_SETB: begin
                    st_d.a       = req.reg1 | bit_mask;
                    st_d.dest    = req.reg1 | bit_mask;
                    st_d.dest_we = 1'b1;
                    st_d.z       = 1'b0;
                end
                CAM_OP_CLRB: begin
                    st_d.a       = req.reg1 & ~bit_mask;
                    st_d.dest    = req.reg1 & ~bit_mask;
                    st_d.dest_we = 1'b1;
                    st_d.z       = ((req.reg1 & ~bit_mask) == 8'h00);
                end
                CAM_OP_INVB: begin
                    st_d.a       = req.reg1 ^ bit_mask;
                    st_d.dest    = req.reg1 ^ bit_mask;
                    st_d.dest_we = 1'b1;
                    st_d.z       = ((req.reg1 ^ bit_mask) == 8'h00);
                end
                CAM_OP_SFLAG: begin
                    st_d.a           = 8'h00;
                    st_d.a[CAM_SF_C] = st_q.c;
                    st_d.a[CAM_SF_V] = st_q.v;
                    st_d.a[CAM_SF_Z] = st_q.z;
                end
                CAM_OP_RFLAG_R, CAM_OP_RFLAG_M: begin
                    st_d.a = {rf_src[6:0], 1'b0};
                    st_d.c = rf_src[CAM_SIGN];
                    st_d.z = (rf_src[6:0] == 7'h00);
                end
                default: begin
                    st_d.valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q <= CAM_ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign rsp_valid = st_q.valid;
    assign a_q       = st_q.a;
    assign dest_q    = st_q.dest;
    assign dest_we   = st_q.dest_we;
    assign c_q       = st_q.c;
    assign v_q       = st_q.v;
    assign z_q       = st_q.z;

    // checks: all on mclk, held off during reset
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    function automatic logic [15:0] mul16(input logic [7:0] x, input logic [7:0] y);
        mul16 = {8'h00, x} * {8'h00, y};
    endfunction

    sequence s_issue(cam_op_t o);
        req_valid && (req.op == o);
    endsequence

    sequence s_answer;
        rsp_valid;
    endsequence

    sequence s_flags_kept;
        $stable(c_q) && $stable(v_q) && $stable(z_q);
    endsequence

    sequence s_bit_op;
        req_valid && (req.op inside {CAM_OP_TSTB, CAM_OP_SETB, CAM_OP_CLRB, CAM_OP_INVB});
    endsequence

    // save issued right behind a compare must see that compare's flags
    sequence s_cmp_then_save;
        req_valid && (req.op inside {CAM_OP_CMP_IMM, CAM_OP_CMP_RR, CAM_OP_CMP_MEM}) ##1 s_issue(CAM_OP_SFLAG);
    endsequence

    mul_rr_a: assert property (s_issue(CAM_OP_MUL_RR) |=> s_answer and
        ({dest_q, a_q} == mul16($past(req.reg2), $past(req.reg1))) && dest_we)
        else $error("two-register product wrong");

    mul_rrr_a: assert property (s_issue(CAM_OP_MUL_RRR) |=>
        s_answer ##0 ({dest_q, a_q} == mul16($past(req.reg2), $past(req.reg3))))
        else $error("three-register product wrong");

    mul_mem_a: assert property (s_issue(CAM_OP_MUL_MEM) |=>
        {dest_q, a_q} == mul16($past(req.data_memory), $past(req.reg1)))
        else $error("memory product wrong");

    mul_imm_a: assert property (s_issue(CAM_OP_MUL_IMM) |=>
        {dest_q, a_q} == mul16($past(req.imm), $past(req.reg1)))
        else $error("immediate product wrong");

    mul_flags_a: assert property ((req_valid && (req.op inside {CAM_OP_MUL_RR, CAM_OP_MUL_RRR,
        CAM_OP_MUL_MEM, CAM_OP_MUL_IMM, CAM_OP_MSHL, CAM_OP_MSHR, CAM_OP_MSHRA}))
        |=> s_flags_kept ##0 dest_we)
        else $error("product touched flags");

    mshl_a: assert property (s_issue(CAM_OP_MSHL) |=>
        {dest_q, a_q} == ({8'h00, $past(req.reg1)} << $past(req.idx)))
        else $error("left multiply-shift wrong");

    mshr_a: assert property (s_issue(CAM_OP_MSHR) |=>
        (dest_q == ($past(req.reg1) >> $past(req.idx))) && dest_we)
        else $error("right multiply-shift wrong");

    mshra_a: assert property (s_issue(CAM_OP_MSHRA) |=>
        dest_q[CAM_SIGN] == $past(req.reg1[CAM_SIGN]))
        else $error("arithmetic shift lost sign");

    cmp_imm_a: assert property (s_issue(CAM_OP_CMP_IMM) |=>
        (a_q == 8'($past(req.imm) - $past(req.reg1))) && (c_q == ($past(req.imm) >= $past(req.reg1))))
        else $error("immediate compare wrong");

    cmp_rr_a: assert property (s_issue(CAM_OP_CMP_RR) |=>
        (a_q == 8'($past(req.reg2) - $past(req.reg1))) && (c_q == ($past(req.reg2) >= $past(req.reg1))))
        else $error("register compare wrong");

    cmp_mem_a: assert property (s_issue(CAM_OP_CMP_MEM) |=>
        c_q == ($past(req.data_memory) >= $past(req.reg1)) && !dest_we)
        else $error("memory compare wrong");

    cmp_v_a: assert property ((req_valid && (req.op inside {CAM_OP_CMP_IMM, CAM_OP_CMP_RR,
        CAM_OP_CMP_MEM})) |=> v_q == (c_q && !z_q))
        else $error("compare overflow flag wrong");

    tstb_a: assert property (s_issue(CAM_OP_TSTB) |=>
        (a_q == ($past(req.reg1) & (8'h01 << $past(req.idx)))) && !dest_we && $stable(c_q))
        else $error("bit test wrong");

    setb_a: assert property (s_issue(CAM_OP_SETB) |=>
        dest_q[$past(req.idx)] && (a_q == dest_q) && dest_we)
        else $error("bit set wrong");

    clrb_a: assert property (s_issue(CAM_OP_CLRB) |=>
        !dest_q[$past(req.idx)] && (a_q == dest_q) && ((a_q | (8'h01 << $past(req.idx))) ==
        ($past(req.reg1) | (8'h01 << $past(req.idx)))))
        else $error("bit clear wrong");

    invb_a: assert property (s_issue(CAM_OP_INVB) |=>
        ((a_q ^ $past(req.reg1)) == (8'h01 << $past(req.idx))) && (dest_q == a_q) && $stable(v_q))
        else $error("bit invert wrong");

    sflag_a: assert property (s_issue(CAM_OP_SFLAG) |=>
        (a_q[CAM_SF_C] == $past(c_q)) and s_flags_kept)
        else $error("flag save wrong");

    rflag_a: assert property (s_issue(CAM_OP_RFLAG_M) or s_issue(CAM_OP_RFLAG_R) |=>
        (a_q[0] == 1'b0) && (c_q == $past(req.op == CAM_OP_RFLAG_M ? req.data_memory[7] : req.reg1[7])))
        else $error("flag restore wrong");

    zero_a: assert property (req_valid && (req.op inside {CAM_OP_CMP_RR, CAM_OP_TSTB,
        CAM_OP_CLRB, CAM_OP_INVB, CAM_OP_RFLAG_R}) |=> z_q == (a_q == 8'h00))
        else $error("zero flag does not follow a");

    answer_a: assert property (rsp_valid |-> $past(req_valid) && ($past(req.op) != CAM_OP_NOP))
        else $error("answer without request");

    mshr_low_a: assert property (s_issue(CAM_OP_MSHR) |=>
        a_q == 8'({$past(req.reg1), 8'h00} >> $past(req.idx)))
        else $error("right multiply-shift dropped bits wrong");

    mshra_all_a: assert property (s_issue(CAM_OP_MSHRA) |=>
        {dest_q, a_q} == 16'($signed({$past(req.reg1), 8'h00}) >>> $past(req.idx)))
        else $error("arithmetic multiply-shift wrong");

    cmp_mem_val_a: assert property (s_issue(CAM_OP_CMP_MEM) |=>
        a_q == 8'($past(req.data_memory) - $past(req.reg1)))
        else $error("memory compare difference wrong");

    cmp_nowrite_a: assert property ((req_valid && (req.op inside {CAM_OP_CMP_IMM, CAM_OP_CMP_RR}))
        |=> s_answer ##0 !dest_we)
        else $error("compare wrote the destination");

    cmp_zero_a: assert property ((req_valid && (req.op inside {CAM_OP_CMP_IMM, CAM_OP_CMP_MEM}))
        |=> z_q == (a_q == 8'h00))
        else $error("compare zero flag wrong");

    bit_cv_a: assert property (s_bit_op |=> s_answer ##0 ($stable(c_q) && $stable(v_q)))
        else $error("bit operation touched carry or overflow");

    setb_rest_a: assert property (s_issue(CAM_OP_SETB) |=>
        (dest_q & ~(8'h01 << $past(req.idx))) == ($past(req.reg1) & ~(8'h01 << $past(req.idx))))
        else $error("bit set changed other bits");

    setb_zero_a: assert property (s_issue(CAM_OP_SETB) |=> !z_q && dest_we)
        else $error("bit set zero flag wrong");

    rflag_shift_a: assert property (s_issue(CAM_OP_RFLAG_M) or s_issue(CAM_OP_RFLAG_R) |=>
        a_q == 8'({$past(req.op == CAM_OP_RFLAG_M ? req.data_memory : req.reg1), 1'b0}))
        else $error("flag restore shift wrong");

    rflag_zero_a: assert property (s_issue(CAM_OP_RFLAG_M) |=> (z_q == (a_q == 8'h00)) && !dest_we)
        else $error("flag restore zero flag wrong");

    sflag_low_a: assert property (s_issue(CAM_OP_SFLAG) |=>
        (a_q[4:0] == 5'h00) && !dest_we)
        else $error("flag save low bits wrong");

    cmp_save_a: assert property (s_cmp_then_save |=>
        (a_q[CAM_SF_Z] == ($past(a_q) == 8'h00)) && (a_q[CAM_SF_V] == (a_q[CAM_SF_C] && !a_q[CAM_SF_Z])))
        else $error("flag save after compare wrong");

endmodule

// *** cam_regfile.sv ***
// register file model standing in for the decoder side of the unit
`timescale 1ns/10ps
module cam_regfile
    import cam_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        req_valid,
    input  wire logic [1:0]  sel1,
    input  wire logic [1:0]  sel2,
    input  wire logic [1:0]  sel3,
    input  wire logic        ld,
    input  wire logic [7:0]  ld_data,
    input  wire logic        dest_we,
    input  wire logic [7:0]  dest_q,
    output logic [7:0]       reg1,
    output logic [7:0]       reg2,
    output logic [7:0]       reg3
);
    logic [7:0] rf_q [4];
    logic [1:0] wsel_q;

    assign reg1 = rf_q[sel1];
    assign reg2 = rf_q[sel2];
    assign reg3 = rf_q[sel3];

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) begin
                rf_q[i] <= 8'h00;
            end
            wsel_q <= 2'h0;
        end else begin
            if (req_valid) begin
                wsel_q <= sel1;
            end
            // write-back wins, a load stands in for other cpu traffic
            if (dest_we) begin
                rf_q[wsel_q] <= dest_q;
            end else if (ld) begin
                rf_q[sel1] <= ld_data;
            end
        end
    end
endmodule

// *** cam_alu_bench.sv ***
// self-checking bench for the multiply, compare and bit unit
`timescale 1ns/10ps
module cam_alu_bench;
    import cam_pkg::*;
    localparam logic [7:0] EDGE_V [4] = '{8'h00, 8'hFF, 8'h80, 8'h01};
    logic        mclk;
    logic        rstn;
    logic        req_valid;
    cam_req_t    req;
    cam_op_t     op;
    logic [7:0]  mem, imm, r1, r2, r3, ld_data, a_q, dest_q, ea, ed;
    logic [2:0]  idx;
    logic [1:0]  s1, s2, s3;
    logic        ld, rsp_valid, dest_we, c_q, v_q, z_q, ec, ev, ez, ersp, ewe;
    int          seed = 16467;
    int          fails = 0;
    int          total_checks = 0;
    logic [31:0] r;

    assign req = {op, r1, r2, r3, mem, imm, idx};

    cam_alu dut (.mclk(mclk), .rstn(rstn), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
        .a_q(a_q), .dest_q(dest_q), .dest_we(dest_we), .c_q(c_q), .v_q(v_q), .z_q(z_q));
    cam_regfile prt (.mclk(mclk), .rstn(rstn), .req_valid(req_valid), .sel1(s1), .sel2(s2), .sel3(s3),
        .ld(ld), .ld_data(ld_data), .dest_we(dest_we), .dest_q(dest_q), .reg1(r1), .reg2(r2), .reg3(r3));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] pick(input logic [31:0] v);
        // boundary operands often, so equal compares and zero results occur
        return v[4] ? EDGE_V[v[1:0]] : v[12:5];
    endfunction

    task automatic model;
        logic [15:0] p;
        logic [8:0]  df;
        logic [7:0]  x;
        p = 16'h0000;
        df = 9'h000;
        x = 8'h00;
        ersp = 1'b1;
        case (req.op)
            CAM_OP_MUL_RR:  p = 16'(req.reg2) * req.reg1;
            CAM_OP_MUL_RRR: p = 16'(req.reg2) * req.reg3;
            CAM_OP_MUL_MEM: p = 16'(req.data_memory) * req.reg1;
            CAM_OP_MUL_IMM: p = 16'(req.imm) * req.reg1;
            CAM_OP_MSHL:    p = 16'(req.reg1) << req.idx;
            CAM_OP_MSHR:    p = {req.reg1, 8'h00} >> req.idx;
            CAM_OP_MSHRA:   p = $signed({req.reg1, 8'h00}) >>> req.idx;
            CAM_OP_CMP_IMM: df = {1'b0, req.imm} - {1'b0, req.reg1};
            CAM_OP_CMP_RR:  df = {1'b0, req.reg2} - {1'b0, req.reg1};
            CAM_OP_CMP_MEM: df = {1'b0, req.data_memory} - {1'b0, req.reg1};
            CAM_OP_TSTB:    ea = req.reg1 & (8'h01 << req.idx);
            CAM_OP_SETB:    ed = req.reg1 | (8'h01 << req.idx);
            CAM_OP_CLRB:    ed = req.reg1 & ~(8'h01 << req.idx);
            CAM_OP_INVB:    ed = req.reg1 ^ (8'h01 << req.idx);
            CAM_OP_SFLAG:   ea = {ec, ev, ez, 5'h00};
            CAM_OP_RFLAG_R: x = req.reg1;
            CAM_OP_RFLAG_M: x = req.data_memory;
            default:        ersp = 1'b0;
        endcase
        if (req.op inside {[CAM_OP_MUL_RR:CAM_OP_MSHRA]}) begin
            ea = p[7:0];
            ed = p[15:8];
            ewe = 1'b1;
        end
        if (req.op inside {[CAM_OP_CMP_IMM:CAM_OP_CMP_MEM]}) begin
            ea = df[7:0];
            ec = !df[8];
            ez = (ea == 8'h00);
            ev = ec & !ez;
        end
        if (req.op inside {[CAM_OP_SETB:CAM_OP_INVB]}) begin
            ea = ed;
            ewe = 1'b1;
        end
        if (req.op inside {CAM_OP_RFLAG_R, CAM_OP_RFLAG_M}) begin
            ea = {x[6:0], 1'b0};
            ec = x[7];
        end
        if (req.op inside {[CAM_OP_TSTB:CAM_OP_INVB], CAM_OP_RFLAG_R, CAM_OP_RFLAG_M}) begin
            ez = (ea == 8'h00);
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        test_done();
    end

    initial begin
        {rstn, req_valid, ld, ld_data, mem, imm, idx, s1, s2, s3} = '0;
        op = CAM_OP_NOP;
        for (int pass = 0; pass < 2; pass++) begin
            // second pass resets in mid-run with state loaded
            @(posedge mclk);
            #2;
            rstn = 1'b0;
            req_valid = 1'b0;
            ld = 1'b0;
            {ea, ed, ec, ev, ez} = {CAM_A_RST, CAM_D_RST, CAM_C_RST, CAM_V_RST, CAM_Z_RST};
            {ersp, ewe} = 2'b00;
            repeat (8) @(posedge mclk);
            #2;
            chk8(a_q, ea);
            rstn = 1'b1;
            repeat (1500) begin
                @(posedge mclk);
                #2;
                chk1(rsp_valid, ersp);
                chk1(dest_we, ewe);
                chk8(a_q, ea);
                chk8(dest_q, ed);
                chk1(c_q, ec);
                chk1(v_q, ev);
                chk1(z_q, ez);
                r = $random(seed);
                req_valid = (r[1:0] != 2'b00);
                op = cam_op_t'(5'(r[6:2] % 20));
                idx = r[9:7];
                {s1, s2, s3} = r[15:10];
                ld = !req_valid;
                ld_data = pick($random(seed));
                mem = pick($random(seed));
                imm = pick($random(seed));
                #1;
                {ersp, ewe} = 2'b00;
                if (req_valid) begin
                    model();
                end
            end
        end
        test_done();
    end
endmodule
